// file: core/wdt_pkg.sv
// Package for the watchdog timer unit: register map, fields, timing constants and types
package wdt_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned OSC_HZ = 32_000;
	// Main clock cycles per watchdog oscillator tick (longest count rounds down)
	localparam int unsigned OSC_DIV_CYC = CLK_HZ / OSC_HZ;
	localparam int unsigned PRE_SHORT = 32;
	localparam int unsigned PRE_LONG = 128;
	localparam int unsigned POST_W = 4;
	localparam int unsigned POST_CNT_W = 15;
	localparam int unsigned PRE_CNT_W = 7;

	localparam logic [11:0] ADDR_CONFIG = 12'h000;
	localparam logic [11:0] ADDR_RESET_CTRL = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_CLEAR = 12'h00C;

	// Watchdog config word fields
	localparam int unsigned CFG_POST_LSB = 0;
	localparam int unsigned CFG_PRE_BIT = 4;
	localparam int unsigned CFG_HWEN_BIT = 5;
	localparam int unsigned CFG_WINDOW_DISABLE_CFG_BIT = 6;
	localparam int unsigned CFG_WIN_LSB = 8;
	localparam logic [31:0] CFG_RESET = 32'h0000_007F;

	// Reset control register fields
	localparam int unsigned RC_IDLE_BIT = 2;
	localparam int unsigned RC_SLEEP_BIT = 3;
	localparam int unsigned RC_TIMEOUT_BIT = 4;
	localparam int unsigned RC_SWEN_BIT = 5;

	// Clear register command bits
	localparam int unsigned CMD_CLRWD_BIT = 0;
	localparam int unsigned CMD_SAVE_BIT = 1;
	localparam int unsigned CMD_IDLE_BIT = 2;

	localparam logic [1:0] WIN_25 = 2'h3;
	localparam logic [1:0] WIN_375 = 2'h2;
	localparam logic [1:0] WIN_50 = 2'h1;
	localparam logic [1:0] WIN_75 = 2'h0;

	typedef enum logic [2:0] {
		PM_RUN = 3'b001,
		PM_SLEEP = 3'b010,
		PM_IDLE = 3'b100
	} wdt_pmode_type;

	typedef struct packed {
		logic [POST_W-1:0] post_sel;
		logic pre_sel;
		logic hw_en;
		logic win_dis;
		logic [1:0] win_sel;
	} wdt_cfg_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} wdt_apb_req_type;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} wdt_apb_rsp_type;
endpackage : wdt_pkg

// file: core/wdt_tick_gen.sv
// Tick source standing in for the low-power RC oscillator of the watchdog
`timescale 1ns/1ns
`default_nettype none
module wdt_tick_gen
	import wdt_pkg::*;
#(
	parameter int unsigned DIV = OSC_DIV_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic run,
	input wire logic restart,
	output logic tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} wdt_tick_state_type;

	localparam logic [15:0] LAST = 16'(DIV - 1);

	wdt_tick_state_type s_q;
	wdt_tick_state_type s_d;

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!run || restart) begin
			s_d.cnt = 16'h0000;
		end else if (s_q.cnt == LAST) begin
			s_d.cnt = 16'h0000;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;
endmodule : wdt_tick_gen
`default_nettype wire

// file: core/wdt_unit.sv
// Watchdog timer unit with APB register access
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module wdt_unit
	import wdt_pkg::*;
#(
	parameter int unsigned TICK_DIV = OSC_DIV_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic clock_switch_done,
	input wire logic wake_event,
	output logic low_power_rc_osc_en,
	output logic wdt_reset_req,
	output logic wdt_wake,
	output logic [2:0] power_mode
);
	typedef struct packed {
		wdt_cfg_type cfg;
		logic sw_en;
		logic timeout_flag;
		logic sleep_flag;
		logic idle_flag;
		wdt_pmode_type pmode;
		logic [PRE_CNT_W-1:0] pre_cnt;
		logic [POST_CNT_W-1:0] post_cnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic osc_en;
		logic rst_req;
		logic wake;
		logic early_fault;
	} wdt_state_type;

	wdt_state_type s_q;
	wdt_state_type s_d;
	logic tick;
	logic enabled;
	logic restart;

	// Terminal postscaler count for a select value, ratio two to the n
	function automatic logic [POST_CNT_W-1:0] post_last(input logic [POST_W-1:0] sel);
		logic [POST_CNT_W:0] one;
		one = {{POST_CNT_W{1'b0}}, 1'b1};
		post_last = POST_CNT_W'((one << sel) - one);
	endfunction : post_last

	// Postscaler count at which the clear window opens
	function automatic logic [POST_CNT_W-1:0] win_open(input logic [POST_CNT_W-1:0] last, input logic [1:0] sel);
		logic [POST_CNT_W+2:0] full;
		full = {3'b000, last} + 18'h00001;
		case (sel)
			WIN_25: win_open = POST_CNT_W'(full - (full >> 2));
			WIN_375: win_open = POST_CNT_W'(full - (full >> 2) - (full >> 3));
			WIN_50: win_open = POST_CNT_W'(full >> 1);
			WIN_75: win_open = POST_CNT_W'(full >> 2);
			default: win_open = '0;
		endcase
	endfunction : win_open

	// Software enable only counts when hardware enable is clear
	assign enabled = s_q.cfg.hw_en | s_q.sw_en;

	wdt_tick_gen #(
		.DIV(TICK_DIV)
	) u_tick (
		.clk(clk),
		.arst_n(arst_n),
		.run(enabled),
		.restart(restart),
		.tick(tick)
	);

	logic apb_wr;
	logic apb_rd;
	logic cmd_clr;
	logic cmd_save;
	logic [PRE_CNT_W-1:0] pre_last;
	logic [POST_CNT_W-1:0] p_last;
	logic expire;
	logic leave_save;

	assign apb_wr = psel && penable && pwrite && !s_q.pready;
	assign apb_rd = psel && penable && !pwrite && !s_q.pready;
	assign cmd_clr = apb_wr && paddr == ADDR_CLEAR && pstrb[0] && pwdata[CMD_CLRWD_BIT] && s_q.pmode == PM_RUN;
	assign cmd_save = apb_wr && paddr == ADDR_CLEAR && pstrb[0] && pwdata[CMD_SAVE_BIT] && s_q.pmode == PM_RUN;
	assign leave_save = s_q.pmode != PM_RUN && (wake_event || expire);
	assign pre_last = s_q.cfg.pre_sel ? PRE_CNT_W'(PRE_LONG - 1) : PRE_CNT_W'(PRE_SHORT - 1);
	assign p_last = post_last(s_q.cfg.post_sel);
	assign expire = enabled && tick && s_q.pre_cnt == pre_last && s_q.post_cnt == p_last;
	// Count restart sources
	assign restart = clock_switch_done || cmd_clr || cmd_save || leave_save;

	always_comb begin
		s_d = s_q;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		s_d.rst_req = 1'b0;
		s_d.wake = 1'b0;
		s_d.early_fault = 1'b0;
		s_d.osc_en = enabled;

		// Counters keep running in every power mode
		if (restart) begin
			s_d.pre_cnt = '0;
			s_d.post_cnt = '0;
		end else if (enabled && tick) begin
			if (s_q.pre_cnt == pre_last) begin
				s_d.pre_cnt = '0;
				s_d.post_cnt = (s_q.post_cnt == p_last) ? '0 : s_q.post_cnt + 1'b1;
			end else begin
				s_d.pre_cnt = s_q.pre_cnt + 1'b1;
			end
		end

		// Early clear in windowed mode is a fault
		if (cmd_clr && !s_q.cfg.win_dis && s_q.post_cnt < win_open(p_last, s_q.cfg.win_sel)) begin
			s_d.early_fault = 1'b1;
		end

		if (cmd_save) begin
			s_d.pmode = pwdata[CMD_IDLE_BIT] ? PM_IDLE : PM_SLEEP;
		end
		if (leave_save) begin
			s_d.pmode = PM_RUN;
		end

		// APB register access, software clears of flags
		if (apb_wr) begin
			case (paddr)
				ADDR_CONFIG: begin
					if (pstrb[0]) begin
						s_d.cfg.post_sel = pwdata[CFG_POST_LSB +: POST_W];
						s_d.cfg.pre_sel = pwdata[CFG_PRE_BIT];
						s_d.cfg.hw_en = pwdata[CFG_HWEN_BIT];
						s_d.cfg.win_dis = pwdata[CFG_WINDOW_DISABLE_CFG_BIT];
					end
					if (pstrb[1]) begin
						s_d.cfg.win_sel = pwdata[CFG_WIN_LSB +: 2];
					end
				end
				ADDR_RESET_CTRL: begin
					if (pstrb[0]) begin
						s_d.sw_en = pwdata[RC_SWEN_BIT];
						s_d.timeout_flag = pwdata[RC_TIMEOUT_BIT];
						s_d.sleep_flag = pwdata[RC_SLEEP_BIT];
						s_d.idle_flag = pwdata[RC_IDLE_BIT];
					end
				end
				ADDR_CLEAR: begin
				end
				default: s_d.pslverr = 1'b1;
			endcase
			s_d.pready = 1'b1;
		end else if (apb_rd) begin
			s_d.pready = 1'b1;
			s_d.prdata = '0;
			case (paddr)
				ADDR_CONFIG: begin
					s_d.prdata[CFG_POST_LSB +: POST_W] = s_q.cfg.post_sel;
					s_d.prdata[CFG_PRE_BIT] = s_q.cfg.pre_sel;
					s_d.prdata[CFG_HWEN_BIT] = s_q.cfg.hw_en;
					s_d.prdata[CFG_WINDOW_DISABLE_CFG_BIT] = s_q.cfg.win_dis;
					s_d.prdata[CFG_WIN_LSB +: 2] = s_q.cfg.win_sel;
				end
				ADDR_RESET_CTRL: begin
					s_d.prdata[RC_SWEN_BIT] = s_q.sw_en;
					s_d.prdata[RC_TIMEOUT_BIT] = s_q.timeout_flag;
					s_d.prdata[RC_SLEEP_BIT] = s_q.sleep_flag;
					s_d.prdata[RC_IDLE_BIT] = s_q.idle_flag;
				end
				ADDR_STATUS: begin
					s_d.prdata[PRE_CNT_W-1:0] = s_q.pre_cnt;
					s_d.prdata[16 +: POST_CNT_W] = s_q.post_cnt;
				end
				ADDR_CLEAR: begin
				end
				default: s_d.pslverr = 1'b1;
			endcase
		end

		// Hardware sets win over software clears
		if (cmd_save) begin
			s_d.sleep_flag = s_d.sleep_flag | ~pwdata[CMD_IDLE_BIT];
			s_d.idle_flag = s_d.idle_flag | pwdata[CMD_IDLE_BIT];
		end
		if (expire || s_d.early_fault) begin
			s_d.timeout_flag = 1'b1;
		end
		if (expire && s_q.pmode != PM_RUN) begin
			s_d.wake = 1'b1;
		end
		if ((expire && s_q.pmode == PM_RUN) || s_d.early_fault) begin
			s_d.rst_req = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
			s_q.cfg <= wdt_cfg_type'({CFG_RESET[3:0], CFG_RESET[4], CFG_RESET[5], CFG_RESET[6], 2'b00});
			s_q.pmode <= PM_RUN;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign low_power_rc_osc_en = s_q.osc_en;
	assign wdt_reset_req = s_q.rst_req;
	assign wdt_wake = s_q.wake;
	assign power_mode = s_q.pmode;
endmodule : wdt_unit
`default_nettype wire

// file: sim/tb_wdt_unit.sv
// Self-checking bench for the watchdog unit
`timescale 1ns/1ns
`default_nettype none
module tb_wdt_unit
	import wdt_pkg::*;
;
	logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic clock_switch_done = 1'b0, wake_event = 1'b0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, low_power_rc_osc_en, wdt_reset_req, wdt_wake;
	logic [2:0] power_mode;
	int errors = 0, comparisons = 0, cyc = 0, req_count = 0;
	always #10 clk = ~clk;
	wdt_unit #(.TICK_DIV(4)) DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clock_switch_done(clock_switch_done),
		.wake_event(wake_event), .low_power_rc_osc_en(low_power_rc_osc_en),
		.wdt_reset_req(wdt_reset_req), .wdt_wake(wdt_wake), .power_mode(power_mode));
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle so a following call never reassigns psel in the same time step
		@(posedge clk);
	endtask : apb
	task automatic wait_ev(input int max, output int n);
		n = 0;
		while (wdt_reset_req !== 1'b1 && wdt_wake !== 1'b1 && n < max) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_ev
	task automatic setcfg(input logic [31:0] v);
		apb(1'b1, ADDR_CONFIG, v);
		apb(1'b1, ADDR_CLEAR, 32'h1);
	endtask : setcfg
	task automatic t_reset();
		apb(1'b0, ADDR_CONFIG, 32'h0);
		chk("config", CFG_RESET, rd);
		apb(1'b0, ADDR_RESET_CTRL, 32'h0);
		chk("reset_control_reg", 32'h0, rd);
		chk("osc", 32'h1, 32'(low_power_rc_osc_en));
		apb(1'b0, 12'h010, 32'h0);
		chk("slverr", 32'h1, 32'(err));
	endtask : t_reset
	task automatic t_period();
		logic [31:0] cfgs [3] = '{32'h60, 32'h70, 32'h61};
		int ticks [3] = '{32, 128, 64};
		int n;
		foreach (cfgs[i]) begin
			setcfg(cfgs[i]);
			wait_ev(1200, n);
			chk("req", 32'h1, 32'(wdt_reset_req));
			chk("period", 32'h1, 32'(n > ticks[i] * 4 - 9 && n < ticks[i] * 4 + 9));
		end
		apb(1'b0, ADDR_RESET_CTRL, 32'h0);
		chk("flag", 32'h1, 32'(rd[RC_TIMEOUT_BIT]));
		apb(1'b1, ADDR_RESET_CTRL, 32'h0);
		apb(1'b0, ADDR_RESET_CTRL, 32'h0);
		chk("flag clr", 32'h0, 32'(rd[RC_TIMEOUT_BIT]));
	endtask : t_period
	task automatic t_clear();
		int n;
		setcfg(32'h60);
		repeat (3) begin
			wait_ev(90, n);
			chk("no req", 32'(90), 32'(n));
			apb(1'b1, ADDR_CLEAR, 32'h1);
		end
		wait_ev(90, n);
		clock_switch_done <= 1'b1;
		@(posedge clk);
		clock_switch_done <= 1'b0;
		wait_ev(100, n);
		chk("switch", 32'(100), 32'(n));
	endtask : t_clear
	task automatic t_sleep();
		int n;
		setcfg(32'h60);
		wait_ev(90, n);
		apb(1'b1, ADDR_CLEAR, 32'h2);
		@(posedge clk);
		chk("sleep", 32'(PM_SLEEP), 32'(power_mode));
		wait_ev(90, n);
		wake_event <= 1'b1;
		@(posedge clk);
		wake_event <= 1'b0;
		@(posedge clk);
		chk("exit", 32'(PM_RUN), 32'(power_mode));
		wait_ev(100, n);
		chk("exit restart", 32'(100), 32'(n));
		apb(1'b1, ADDR_CLEAR, 32'h2);
		wait_ev(200, n);
		chk("wake", 32'h1, 32'(wdt_wake && !wdt_reset_req));
		@(posedge clk);
		chk("resume", 32'(PM_RUN), 32'(power_mode));
		apb(1'b0, ADDR_RESET_CTRL, 32'h0);
		chk("sleep bit", 32'h1, 32'(rd[RC_SLEEP_BIT]));
		apb(1'b1, ADDR_RESET_CTRL, 32'h0);
		apb(1'b1, ADDR_CLEAR, 32'h6);
		@(posedge clk);
		chk("idle", 32'(PM_IDLE), 32'(power_mode));
		wait_ev(200, n);
		chk("idle wake", 32'h1, 32'(wdt_wake));
	endtask : t_sleep
	task automatic t_swen();
		int n;
		setcfg(32'h40);
		apb(1'b1, ADDR_RESET_CTRL, 32'h0);
		wait_ev(300, n);
		chk("sw off", 32'(300), 32'(n));
		chk("osc off", 32'h0, 32'(low_power_rc_osc_en));
		apb(1'b1, ADDR_RESET_CTRL, 32'h20);
		wait_ev(200, n);
		chk("sw on", 32'h1, 32'(wdt_reset_req));
	endtask : t_swen
	task automatic t_window();
		int n;
		int seen;
		for (int s = 0; s < 4; s++) begin
			setcfg(32'(32'h62 | (s << 8)));
			apb(1'b1, ADDR_CONFIG, 32'(32'h22 | (s << 8)));
			wait_ev(190, n);
			seen = req_count;
			apb(1'b1, ADDR_CLEAR, 32'h1);
			wait_ev(4, n);
			chk("early clear", 32'(s != 0), 32'(req_count != seen));
		end
	endtask : t_window
	// Counts reset request pulses so a pulse cannot slip past a busy task
	always @(posedge clk) begin
		if (wdt_reset_req === 1'b1) begin
			req_count <= req_count + 1;
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			end_of_test();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_period();
		t_clear();
		t_sleep();
		t_swen();
		t_window();
		end_of_test();
	end
endmodule : tb_wdt_unit
`default_nettype wire

// file: sim/wdt_unit_properties.sv
// Port-level assertions for the watchdog unit
`timescale 1ns/1ns
`default_nettype none
module wdt_unit_properties
	import wdt_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic low_power_rc_osc_en,
	input wire logic wdt_reset_req,
	input wire logic wdt_wake,
	input wire logic [2:0] power_mode
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	AST_RDY_PULSE: assert property (pready |=> !pready) else $error("pready held too long");
	AST_RDY_CAUSE: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
	AST_ERR_RDY: assert property (pslverr |-> pready) else $error("pslverr without pready");
	AST_WAKE_MODE: assert property (wdt_wake |-> $past(power_mode) != PM_RUN) else $error("wake in run");
	AST_WAKE_RUN: assert property (wdt_wake |-> ##[0:1] power_mode == PM_RUN) else $error("no resume");
	AST_REQ_RUN: assert property (wdt_reset_req |-> !wdt_wake && power_mode == PM_RUN) else $error("bad req");
	AST_REQ_PULSE: assert property (wdt_reset_req |=> !wdt_reset_req) else $error("req held too long");
	AST_WAKE_OSC: assert property (wdt_wake |-> low_power_rc_osc_en) else $error("wake while off");
	AST_MODE_HOT: assert property ($onehot(power_mode)) else $error("power mode not one-hot");
	cover property (wdt_wake);
	cover property (wdt_reset_req);
	cover property (pslverr);
endmodule : wdt_unit_properties
bind wdt_unit wdt_unit_properties u_props (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .low_power_rc_osc_en(low_power_rc_osc_en),
	.wdt_reset_req(wdt_reset_req), .wdt_wake(wdt_wake), .power_mode(power_mode));
`default_nettype wire
